/* File: pkg/uart_lsr_pkg.sv */
`default_nettype none
package uart_lsr_pkg;
    // receive fifo geometry
    localparam int RX_DEPTH = 128;
    localparam int RX_AW = 7;
    localparam int RX_CW = 8;
    localparam logic [7:0] RX_CAP_FIFO = 8'h80; // fifo mode capacity
    localparam logic [7:0] RX_CAP_HOLD = 8'h01; // single holding register
    // register byte offsets
    localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
    // line_status field positions
    localparam int LS_RDY = 0;
    localparam int LS_OVR = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BRK = 4;
    localparam int LS_THRE = 5;
    localparam int LS_TEMT = 6;
    localparam int LS_FERR = 7;
    // control field positions and reset value
    localparam int CTL_FIFO_MODE = 0;
    localparam int CTL_THRE_IE = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;
    // interrupt status / enable / clear layout
    localparam int IRQ_W = 4;
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_LINE_ERR = 2;
    localparam int IRQ_BRK = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // one received character with its error tags
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } rx_entry_t;
    // break detector states, gray along idle-count-held
    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_COUNT = 2'b01,
        BRK_HELD = 2'b11
    } brk_state_t;
endpackage
`default_nettype wire

/* File: core/rx_tag_mem.sv */
`default_nettype none
module rx_tag_mem
    import uart_lsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [RX_AW-1:0] wr_addr,
    input wire rx_entry_t wr_data,
    input wire logic [RX_AW-1:0] rd_addr,
    output rx_entry_t rd_data
);
    rx_entry_t mem_q [RX_DEPTH]; // character and tag storage
    rx_entry_t rd_d; // next read word

    // read with write-through so a fresh push is seen at once
    always_comb begin
        if (wr_en && wr_addr == rd_addr) begin
            rd_d = wr_data;
        end else begin
            rd_d = mem_q[rd_addr];
        end
    end

    // storage and registered read data
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
            rd_data <= rd_d;
        end
    end
endmodule // rx_tag_mem
`default_nettype wire

/* File: core/uart_line_status_flags.sv */
// Design decisions made here: the placing of the registers and the Wishbone register port.
`default_nettype none
module uart_line_status_flags
    import uart_lsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic rx_serial_in,
    input wire logic baud_tick,
    input wire logic [3:0] frame_bits,
    input wire logic rx_char_valid,
    input wire rx_entry_t rx_char,
    input wire logic tx_load,
    input wire logic tx_move,
    input wire logic [7:0] tx_fifo_count,
    input wire logic tx_shift_busy,
    output logic fifo_mode,
    output logic [7:0] line_status,
    output logic irq
);
    // rx pin synchroniser and filtered level
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_level_q, rx_level_d;
    // break detector
    brk_state_t brk_state_q, brk_state_d;
    logic [3:0] low_cnt_q, low_cnt_d;
    logic brk_push; // one pulse per break
    // receive fifo bookkeeping
    logic [RX_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [RX_CW-1:0] count_q, count_d, err_cnt_q, err_cnt_d;
    logic overrun_q, overrun_d;
    rx_entry_t push_entry, head;
    logic push_req, push_ok, pop, full, ovr_evt, push_tag, head_tag, flush;
    // transmit holding register occupancy
    logic holding_full_q, holding_full_d;
    logic holding_empty, tx_empty;
    // software registers and bus
    logic [1:0] ctl_q, ctl_d;
    logic [IRQ_W-1:0] irq_en_q, irq_en_d, irq_sts_q, irq_sts_d, irq_evt;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [7:0] ls_now, ls_q;
    logic acc, rd_acc, wr_acc;

    // three-stage sampling; level moves only when stages two and three agree
    always_comb begin
        rx_level_d = (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_level_q;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_level_q <= 1'b1;
        end else if (clk_en) begin
            rx_s1_q <= rx_serial_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            rx_level_q <= rx_level_d;
        end
    end

    // break detector: counts bit periods of low line, fires once per low spell
    always_comb begin
        brk_state_d = brk_state_q;
        low_cnt_d = low_cnt_q;
        brk_push = 1'b0;
        case (brk_state_q)
            BRK_IDLE: begin
                low_cnt_d = 4'h0;
                if (!rx_level_q) begin
                    brk_state_d = BRK_COUNT;
                end
            end
            BRK_COUNT: begin
                if (rx_level_q) begin
                    brk_state_d = BRK_IDLE;
                end else if (baud_tick) begin
                    if (low_cnt_q + 4'h1 >= frame_bits) begin
                        brk_push = 1'b1;
                        brk_state_d = BRK_HELD;
                    end else begin
                        low_cnt_d = low_cnt_q + 4'h1;
                    end
                end
            end
            BRK_HELD: begin
                // stay silent until the line returns high
                if (rx_level_q) begin
                    brk_state_d = BRK_IDLE;
                end
            end
            default: brk_state_d = BRK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            brk_state_q <= BRK_IDLE;
            low_cnt_q <= 4'h0;
        end else if (clk_en) begin
            brk_state_q <= brk_state_d;
            low_cnt_q <= low_cnt_d;
        end
    end

    // bus access decode, request taken on the edge before ack
    assign acc = wb_cyc && wb_stb && !ack_q;
    assign rd_acc = acc && !wb_we;
    assign wr_acc = acc && wb_we && wb_sel[0];
    assign flush = wr_acc && wb_adr == OFS_CONTROL
                   && wb_dat_w[CTL_FIFO_MODE] != ctl_q[CTL_FIFO_MODE];

    // receive storage with tags alongside each character
    rx_tag_mem u_rx_mem (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(push_ok),
        .wr_addr(wr_ptr_q),
        .wr_data(push_entry),
        .rd_addr(rd_ptr_d),
        .rd_data(head)
    );

    // receive fifo: push, pop, overrun and error count
    always_comb begin
        push_entry = rx_char;
        if (brk_push) begin
            push_entry = '{brk: 1'b1, fe: 1'b0, pe: 1'b0, data: 8'h00};
        end
        push_req = rx_char_valid || brk_push;
        full = count_q >= (ctl_q[CTL_FIFO_MODE] ? RX_CAP_FIFO : RX_CAP_HOLD);
        pop = rd_acc && wb_adr == OFS_RX_DATA && count_q != 8'h00;
        push_ok = push_req && (!full || pop) && !flush;
        ovr_evt = push_req && full && !pop;
        push_tag = push_entry.brk || push_entry.fe || push_entry.pe;
        head_tag = head.brk || head.fe || head.pe;
        wr_ptr_d = push_ok ? wr_ptr_q + 7'h01 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 7'h01 : rd_ptr_q;
        count_d = count_q + {7'h00, push_ok} - {7'h00, pop};
        err_cnt_d = err_cnt_q + {7'h00, push_ok && push_tag}
                    - {7'h00, pop && head_tag};
        overrun_d = overrun_q;
        if (rd_acc && wb_adr == OFS_LINE_STATUS) begin
            overrun_d = 1'b0;
        end
        if (ovr_evt) begin
            overrun_d = 1'b1; // set wins over the read clear
        end
        if (flush) begin
            // mode change empties the receive path
            wr_ptr_d = 7'h00;
            rd_ptr_d = 7'h00;
            count_d = 8'h00;
            err_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= 7'h00;
            rd_ptr_q <= 7'h00;
            count_q <= 8'h00;
            err_cnt_q <= 8'h00;
            overrun_q <= 1'b0;
        end else if (clk_en) begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            err_cnt_q <= err_cnt_d;
            overrun_q <= overrun_d;
        end
    end

    // transmit status and composed line status
    always_comb begin
        holding_full_d = holding_full_q;
        if (tx_move) begin
            holding_full_d = 1'b0;
        end
        if (tx_load) begin
            holding_full_d = 1'b1;
        end
        if (ctl_q[CTL_FIFO_MODE]) begin
            holding_empty = tx_fifo_count == 8'h00;
        end else begin
            holding_empty = !holding_full_q;
        end
        tx_empty = holding_empty && !tx_shift_busy;
        ls_now = 8'h00;
        ls_now[LS_RDY] = count_q != 8'h00;
        ls_now[LS_OVR] = overrun_q;
        // head tags only count while a character waits
        ls_now[LS_PE] = ls_now[LS_RDY] && head.pe;
        ls_now[LS_FE] = ls_now[LS_RDY] && head.fe;
        ls_now[LS_BRK] = ls_now[LS_RDY] && head.brk;
        ls_now[LS_THRE] = holding_empty;
        ls_now[LS_TEMT] = tx_empty;
        ls_now[LS_FERR] = ctl_q[CTL_FIFO_MODE] && err_cnt_q != 8'h00;
    end

    // interrupt events and register writes
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_RX] = push_ok;
        irq_evt[IRQ_OVR] = ovr_evt;
        irq_evt[IRQ_LINE_ERR] = push_ok && push_tag;
        irq_evt[IRQ_BRK] = brk_push;
        ctl_d = ctl_q;
        irq_en_d = irq_en_q;
        irq_sts_d = irq_sts_q;
        if (wr_acc && wb_adr == OFS_CONTROL) begin
            ctl_d = wb_dat_w[1:0];
        end
        if (wr_acc && wb_adr == OFS_IRQ_ENABLE) begin
            irq_en_d = wb_dat_w[IRQ_W-1:0];
        end
        if (wr_acc && wb_adr == OFS_IRQ_CLEAR) begin
            irq_sts_d = irq_sts_q & ~wb_dat_w[IRQ_W-1:0];
        end
        irq_sts_d = irq_sts_d | irq_evt; // set wins over clear
    end

    // read data mux, latched with the ack
    always_comb begin
        ack_d = acc;
        dat_d = dat_q;
        if (rd_acc) begin
            case (wb_adr)
                OFS_LINE_STATUS: dat_d = {24'h00_0000, ls_now};
                OFS_RX_DATA: dat_d = {24'h00_0000, ls_now[LS_RDY] ? head.data : 8'h00};
                OFS_CONTROL: dat_d = {30'h0000_0000, ctl_q};
                OFS_IRQ_STATUS: dat_d = {28'h000_0000, irq_sts_q};
                OFS_IRQ_ENABLE: dat_d = {28'h000_0000, irq_en_q};
                default: dat_d = 32'h0000_0000; // unmapped and write-only read zero
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            holding_full_q <= 1'b0;
            ctl_q <= CTL_RESET;
            irq_en_q <= IRQ_RESET;
            irq_sts_q <= IRQ_RESET;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            ls_q <= 8'h00;
        end else if (clk_en) begin
            holding_full_q <= holding_full_d;
            ctl_q <= ctl_d;
            irq_en_q <= irq_en_d;
            irq_sts_q <= irq_sts_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            ls_q <= ls_now;
        end
    end

    // outputs
    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    assign fifo_mode = ctl_q[CTL_FIFO_MODE];
    assign line_status = ls_q;
    assign irq = (|(irq_sts_q & irq_en_q))
                 || (holding_empty && ctl_q[CTL_THRE_IE]);

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_tagged_push;
        clk_en && push_ok && push_tag && fifo_mode && !flush;
    endsequence
    sequence s_break_fire;
        clk_en && brk_push;
    endsequence

    AST_ERR_SET: assert property (s_tagged_push |=> ##1 line_status[LS_FERR])
        else $error("error summary not set after tagged push");
    AST_ERR_CLR: assert property (count_q == 8'h00 |-> ##1 !line_status[LS_FERR])
        else $error("error summary set with empty fifo");
    AST_TEMT: assert property (clk_en && line_status[LS_TEMT] |->
            $past(holding_empty) && !$past(tx_shift_busy))
        else $error("transmitter empty while data held");
    AST_THRE_LOAD: assert property (clk_en && !fifo_mode && tx_load |=> !holding_empty)
        else $error("holding empty after host load");
    AST_THRE_MOVE: assert property (clk_en && !fifo_mode && tx_move && !tx_load
            |=> holding_empty)
        else $error("holding empty not set after move");
    AST_IRQ_THRE: assert property (holding_empty && ctl_q[CTL_THRE_IE] |-> irq)
        else $error("no interrupt while holding empty enabled");
    AST_THRE_FIFO: assert property (clk_en && fifo_mode && tx_fifo_count != 8'h00
            |=> !line_status[LS_THRE])
        else $error("holding empty with bytes in tx fifo");
    AST_BRK_ONCE: assert property (s_break_fire |=> !brk_push [*3])
        else $error("second break character in one low spell");
    AST_BRK_HELD: assert property (brk_state_q == BRK_HELD |-> !brk_push)
        else $error("break pushed while held");
    AST_BRK_LOW: assert property (s_break_fire |->
            !rx_level_q && low_cnt_q + 4'h1 >= frame_bits)
        else $error("break fired without a full low frame");
    AST_OVR: assert property (clk_en && push_req && full && !pop && !flush
            |=> overrun_q && count_q == $past(count_q))
        else $error("overrun not flagged or fifo changed");
    AST_RDY_DROP: assert property (clk_en && pop && !push_ok && count_q == 8'h01
            |=> ##1 !line_status[LS_RDY])
        else $error("data ready stays after last read");
    AST_RST: assert property ($rose(reset_n) |-> line_status[7] == 1'b0
            && line_status[4:3] == 2'b00)
        else $error("flags not zero after reset");
endmodule // uart_line_status_flags
`default_nettype wire

/* File: verification/wb_host_model.sv */
`default_nettype none
// host processor on the register bus, classic single wishbone cycles
module wb_host_model (
    input wire logic ref_clk,
    output logic wb_cyc,
    output logic wb_stb,
    output logic wb_we,
    output logic [7:0] wb_adr,
    output logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int timeouts; // waits that ran out without an answer
    // bus idle from time zero
    initial begin
        timeouts = 0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat_w = 32'h0000_0000;
    end
    // one access: called just after a rising edge, holds until ack is sampled
    task automatic xfer(input logic we_i, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we_i;
        wb_adr <= a;
        wb_dat_w <= d;
        n = 0;
        // bounded wait for the answer
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) timeouts++;
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_dat_w <= ~d; // released data no longer shows the last value
        // one idle cycle between accesses
        @(posedge ref_clk);
    endtask
endmodule // wb_host_model
`default_nettype wire

/* File: verification/test_uart_line_status_flags.sv */
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module test_uart_line_status_flags
    import uart_lsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, fifo_mode;
    logic [7:0] wb_adr, line_status;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic rx_serial_in = 1'b1; // idle line high
    logic baud_tick = 1'b0;
    logic [3:0] frame_bits = 4'ha; // start, eight data, stop
    logic rx_char_valid = 1'b0;
    rx_entry_t rx_char = '0;
    rx_entry_t e1, e2, e3; // characters sent into the receive path
    logic tx_load = 1'b0;
    logic tx_move = 1'b0;
    logic [7:0] tx_fifo_count = 8'h00;
    logic tx_shift_busy = 1'b0;
    logic held; // bench view of the holding register
    logic clk_en = 1'b1; // freezes the block while low
    logic [1:0] txe; // expected {transmitter empty, holding empty}
    integer seed = 32'hb8f3;
    int num_errors = 0;
    int samples_checked = 0;
    // free running clock, 8 ns period
    always #4 ref_clk = ~ref_clk;
    uart_line_status_flags dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .rx_serial_in(rx_serial_in), .baud_tick(baud_tick), .frame_bits(frame_bits),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_load(tx_load),
        .tx_move(tx_move), .tx_fifo_count(tx_fifo_count), .tx_shift_busy(tx_shift_busy),
        .fifo_mode(fifo_mode), .line_status(line_status), .irq(irq));
    wb_host_model host (.ref_clk(ref_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
    // expected {transmitter empty, holding empty}
    function automatic logic [1:0] tx_exp(logic fm, logic [7:0] cnt, logic busy, logic h);
        logic thre;
        thre = fm ? (cnt == 8'h00) : !h;
        return {thre && !busy, thre};
    endfunction
    // verdict and end of run
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // a bus wait that ran out ends the run
    task automatic guard();
        if (host.timeouts != 0) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, {24'h00_0000, d}, r);
        guard();
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, q);
        guard();
    endtask
    // one received character pulse, then let the flags settle
    task automatic push(input rx_entry_t e);
        rx_char <= e;
        rx_char_valid <= 1'b1;
        cyc(1);
        rx_char_valid <= 1'b0;
        rx_char <= ~e;
        cyc(3);
    endtask
    // global watchdog
    initial begin
        #800000;
        num_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        cyc(20);
        reset_n <= 1'b1;
        cyc(3);
        `CHECK(line_status[7], 1'b0)
        `CHECK(line_status[4:3], 2'b00)
        `CHECK(line_status[6:5], 2'b11)
        held = 1'b0;
        // transmit flags in both modes, holding-empty interrupt enabled outside fifo mode
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CONTROL, {6'h00, !m[0], m[0]});
            for (int i = 0; i < 16; i++) begin
                tx_load <= 1'($random(seed));
                tx_move <= 1'($random(seed));
                tx_shift_busy <= 1'($random(seed));
                tx_fifo_count <= ($random(seed) & 1) ? 8'h00 : 8'h01 + 8'($random(seed) & 8'h7e);
                cyc(1);
                if (tx_load) held = 1'b1;
                else if (tx_move) held = 1'b0;
                tx_load <= 1'b0;
                tx_move <= 1'b0;
                cyc(3);
                txe = tx_exp(m[0], tx_fifo_count, tx_shift_busy, held);
                `CHECK(line_status[6:5], txe)
                `CHECK(irq, txe[0] && !m[0])
            end
        end
        // fifo mode: head tags and error summary
        wr(OFS_CONTROL, 8'h01);
        e1 = '{brk: 1'b0, fe: 1'b1, pe: 1'b0, data: 8'($random(seed))};
        e2 = '{brk: 1'b0, fe: 1'b0, pe: 1'b0, data: 8'($random(seed))};
        e3 = '{brk: 1'b0, fe: 1'b0, pe: 1'b1, data: 8'($random(seed))};
        push(e1);
        push(e2);
        push(e3);
        `CHECK(line_status[0], 1'b1)
        `CHECK({line_status[7], line_status[3:2]}, 3'b110)
        rd(OFS_LINE_STATUS);
        `CHECK(q[7:0], {1'b1, tx_exp(1'b1, tx_fifo_count, tx_shift_busy, held), 5'h09})
        rd(OFS_IRQ_STATUS);
        `CHECK(q[3:0], 4'h5)
        `CHECK(irq, 1'b0)
        wr(OFS_IRQ_ENABLE, 8'h04);
        cyc(1);
        `CHECK(irq, 1'b1)
        wr(OFS_IRQ_CLEAR, 8'h04);
        cyc(1);
        `CHECK(irq, 1'b0)
        rd(8'h1c);
        `CHECK(q, 32'h0000_0000)
        rd(OFS_RX_DATA);
        `CHECK(q[7:0], e1.data)
        cyc(2);
        `CHECK({line_status[7], line_status[3:2]}, 3'b100)
        rd(OFS_RX_DATA);
        `CHECK(q[7:0], e2.data)
        cyc(2);
        `CHECK({line_status[7], line_status[3:2]}, 3'b101)
        rd(OFS_RX_DATA);
        `CHECK(q[7:0], e3.data)
        cyc(2);
        `CHECK({line_status[7], line_status[3:2], line_status[0]}, 4'b0000)
        // break: line held low far beyond one frame
        rx_serial_in <= 1'b0;
        for (int i = 0; i < 30; i++) begin
            baud_tick <= 1'b1;
            cyc(1);
            baud_tick <= 1'b0;
            cyc(3);
        end
        `CHECK({line_status[4], line_status[0]}, 2'b11)
        rd(OFS_IRQ_STATUS);
        `CHECK(q[IRQ_BRK], 1'b1)
        rd(OFS_RX_DATA);
        `CHECK(q[7:0], 8'h00)
        cyc(2);
        `CHECK({line_status[4], line_status[0]}, 2'b00)
        rx_serial_in <= 1'b1;
        // holding register mode: second character overruns
        wr(OFS_CONTROL, 8'h00);
        push(e2);
        push(e3);
        `CHECK(line_status[1:0], 2'b11)
        `CHECK(line_status[7], 1'b0)
        rd(OFS_LINE_STATUS);
        `CHECK(q[1], 1'b1)
        cyc(2);
        `CHECK(line_status[1], 1'b0)
        rd(OFS_RX_DATA);
        `CHECK(q[7:0], e2.data)
        // frozen clock enable: a character offered meanwhile is ignored
        clk_en <= 1'b0;
        push(e1);
        clk_en <= 1'b1;
        cyc(3);
        `CHECK(line_status[0], 1'b0)
        report_and_stop();
    end
endmodule // test_uart_line_status_flags
`undef CHECK
`default_nettype wire
